// ===== pbfs_top.sv
// Port B pin function select, input routing, port registers and wake
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module pbfs_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Port A pins
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe_n,
    // Port B pins
    input wire logic [4:0] pb_in,
    output logic [4:0] pb_out,
    output logic [4:0] pb_oe_n,
    // Serial interface side
    input wire logic serial_iface_enable,
    input wire logic spi_master_mode,
    input wire logic spi_sck_out,
    input wire logic spi_sdo_out,
    output logic serial_clock_in,
    output logic serial_data_in,
    output logic serial_cs_n_in,
    // Timer capture input
    output logic periodic_timer_capture_in,
    // Power state and wake
    input wire logic sleep_idle,
    output logic wake_up
);
    // Registers
    logic [7:0] pb_low_sel_reg, pb_high_sel_reg, input_src_reg;
    logic [7:0] pa_data_reg, pa_dir_reg, pa_wake_en_reg, pa_prev_reg;
    logic [4:0] pb_data_reg, pb_dir_reg;
    logic wake_flag_reg;

    // Bus holding state
    logic aw_held_reg, w_held_reg, wstrb0_reg, bvalid_reg, rvalid_reg;
    logic [7:0] awaddr_reg, wdata_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    // Derived
    logic do_write, wr_low, spi_master_on, wake_event, wake_clear;
    logic [1:0] pb2_func, pb1_func, pb4_func;
    logic [1:0] cap_src, cs_src, sck_src, sdi_src;
    logic [7:0] pa_fall;
    logic [pbfs_pkg::BOP_IDX_W-1:0] bop_idx;

    // Two-bit field out of a select register
    function automatic logic [1:0] field2(input logic [7:0] r,
        input int lsb);
        field2 = r[lsb+:2];
    endfunction : field2

    // Port byte with one bit forced; base is what a port read returns
    function automatic logic [7:0] rmw_bit(input logic [7:0] base,
        input logic [2:0] idx, input logic val);
        rmw_bit = base;
        rmw_bit[idx] = val;
    endfunction : rmw_bit

    // Address decode; only valid while the map stays dense from zero
    function automatic logic addr_known(input logic [7:0] a);
        addr_known = a[1:0] == 2'h0 && a <= pbfs_pkg::OFS_WAKE_STAT;
    endfunction : addr_known

    // Field decode
    assign pb2_func = field2(pb_low_sel_reg, pbfs_pkg::LINE2_FUNC_LSB);
    assign pb1_func = field2(pb_low_sel_reg, pbfs_pkg::LINE1_FUNC_LSB);
    assign pb4_func = field2(pb_high_sel_reg, pbfs_pkg::LINE4_FUNC_LSB);
    assign cap_src = field2(input_src_reg, pbfs_pkg::CAP_SRC_LSB);
    assign cs_src = field2(input_src_reg, pbfs_pkg::CS_SRC_LSB);
    assign sck_src = field2(input_src_reg, pbfs_pkg::SCK_SRC_LSB);
    assign sdi_src = field2(input_src_reg, pbfs_pkg::SDI_SRC_LSB);
    assign spi_master_on = serial_iface_enable & spi_master_mode;

    // Write handshakes: address and data are taken in either order
    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign wr_low = do_write & wstrb0_reg;

    // Read handshakes
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // Write address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    // Write data capture; only byte lane 0 carries register bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata[7:0];
            wstrb0_reg <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    // Write response one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= pbfs_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= addr_known(awaddr_reg) ?
                pbfs_pkg::RESP_OKAY : pbfs_pkg::RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Function select and input source registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pb_low_sel_reg <= pbfs_pkg::RST_SEL;
            pb_high_sel_reg <= pbfs_pkg::RST_SEL;
            input_src_reg <= pbfs_pkg::RST_SEL;
        end else if (wr_low) begin
            if (awaddr_reg == pbfs_pkg::OFS_PB_LOW_SEL)
                pb_low_sel_reg <= wdata_reg;
            if (awaddr_reg == pbfs_pkg::OFS_PB_HIGH_SEL)
                pb_high_sel_reg <= wdata_reg & pbfs_pkg::PB_HIGH_MASK;
            if (awaddr_reg == pbfs_pkg::OFS_INPUT_SRC)
                input_src_reg <= wdata_reg;
        end
    end

    assign bop_idx = wdata_reg[pbfs_pkg::BOP_IDX_LSB+:pbfs_pkg::BOP_IDX_W];

    // Port A data and direction; bit ops read the whole port first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pa_data_reg <= pbfs_pkg::RST_PA;
            pa_dir_reg <= pbfs_pkg::RST_PA;
        end else if (wr_low) begin
            if (awaddr_reg == pbfs_pkg::OFS_PA_DATA)
                pa_data_reg <= wdata_reg;
            if (awaddr_reg == pbfs_pkg::OFS_PA_DIR)
                pa_dir_reg <= wdata_reg;
            if (awaddr_reg == pbfs_pkg::OFS_BIT_OP &&
                !wdata_reg[pbfs_pkg::BOP_PORT_B]) begin
                if (wdata_reg[pbfs_pkg::BOP_DIR])
                    pa_dir_reg <= rmw_bit(pa_dir_reg, bop_idx,
                        wdata_reg[pbfs_pkg::BOP_VAL]);
                else
                    pa_data_reg <= rmw_bit(pa_in, bop_idx,
                        wdata_reg[pbfs_pkg::BOP_VAL]);
            end
        end
    end

    // Port B data and direction; bit ops past bit 4 fall away
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pb_data_reg <= pbfs_pkg::RST_PB;
            pb_dir_reg <= pbfs_pkg::RST_PB;
        end else if (wr_low) begin
            if (awaddr_reg == pbfs_pkg::OFS_PB_DATA)
                pb_data_reg <= wdata_reg[4:0];
            if (awaddr_reg == pbfs_pkg::OFS_PB_DIR)
                pb_dir_reg <= wdata_reg[4:0];
            if (awaddr_reg == pbfs_pkg::OFS_BIT_OP &&
                wdata_reg[pbfs_pkg::BOP_PORT_B]) begin
                if (wdata_reg[pbfs_pkg::BOP_DIR])
                    pb_dir_reg <= 5'(rmw_bit({3'h0, pb_dir_reg},
                        bop_idx, wdata_reg[pbfs_pkg::BOP_VAL]));
                else
                    pb_data_reg <= 5'(rmw_bit({3'h0, pb_in},
                        bop_idx, wdata_reg[pbfs_pkg::BOP_VAL]));
            end
        end
    end

    // Wake enable register
    always_ff @(posedge aclk) begin
        if (!aresetn)
            pa_wake_en_reg <= pbfs_pkg::RST_WAKE_EN;
        else if (wr_low && awaddr_reg == pbfs_pkg::OFS_PA_WAKE_EN)
            pa_wake_en_reg <= wdata_reg;
    end

    // Previous pin levels for edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn)
            pa_prev_reg <= pbfs_pkg::RST_PA;
        else
            pa_prev_reg <= pa_in;
    end

    // High-to-low on any enabled port A pin while asleep
    assign pa_fall = pa_prev_reg & ~pa_in & pa_wake_en_reg;
    assign wake_event = sleep_idle & (|pa_fall);
    assign wake_clear = wr_low &&
        awaddr_reg == pbfs_pkg::OFS_WAKE_STAT &&
        wdata_reg[pbfs_pkg::WAKE_FLAG_BIT];

    // Sticky wake flag; a new edge beats a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn)
            wake_flag_reg <= 1'b0;
        else if (wake_event)
            wake_flag_reg <= 1'b1;
        else if (wake_clear)
            wake_flag_reg <= 1'b0;
    end

    assign wake_up = wake_flag_reg;

    // Read path; data registers read back the pin levels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= pbfs_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= addr_known(s_axi_araddr) ?
                pbfs_pkg::RESP_OKAY : pbfs_pkg::RESP_DECERR;
            case (s_axi_araddr)
                pbfs_pkg::OFS_PB_LOW_SEL:
                    rdata_reg <= {24'h0, pb_low_sel_reg};
                pbfs_pkg::OFS_PB_HIGH_SEL:
                    rdata_reg <= {24'h0, pb_high_sel_reg};
                pbfs_pkg::OFS_INPUT_SRC:
                    rdata_reg <= {24'h0, input_src_reg};
                pbfs_pkg::OFS_PA_DATA: rdata_reg <= {24'h0, pa_in};
                pbfs_pkg::OFS_PA_DIR: rdata_reg <= {24'h0, pa_dir_reg};
                pbfs_pkg::OFS_PB_DATA: rdata_reg <= {27'h0, pb_in};
                pbfs_pkg::OFS_PB_DIR: rdata_reg <= {27'h0, pb_dir_reg};
                pbfs_pkg::OFS_PA_WAKE_EN:
                    rdata_reg <= {24'h0, pa_wake_en_reg};
                pbfs_pkg::OFS_WAKE_STAT:
                    rdata_reg <= {31'h0, wake_flag_reg};
                default:
                    rdata_reg <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Port A stays general I/O in this block
    assign pa_out = pa_data_reg;
    assign pa_oe_n = pa_dir_reg;

    // Port B pin drivers; reserved codes keep the GPIO path
    always_comb begin
        pb_out = pb_data_reg;
        pb_oe_n = pb_dir_reg;
        // Line 1 serial data out
        if (pb1_func == pbfs_pkg::CODE_10) begin
            pb_out[1] = spi_sdo_out;
            pb_oe_n[1] = 1'b0;
        end
        // Line 2 clock: driven as master, listened to as slave
        if (pb2_func == pbfs_pkg::CODE_10) begin
            pb_out[2] = spi_sck_out;
            pb_oe_n[2] = ~spi_master_on;
        end
        // Line 4 chip select is an input; pin left undriven
        if (pb4_func == pbfs_pkg::CODE_01) begin
            pb_oe_n[4] = 1'b1;
        end
    end

    // Capture input; reserved codes give an idle low
    always_comb begin
        if (cap_src == pbfs_pkg::CODE_01)
            periodic_timer_capture_in = pa_in[7];
        else
            periodic_timer_capture_in = 1'b0;
    end

    // Chip select input, idle high when unrouted
    always_comb begin
        unique case (cs_src)
            pbfs_pkg::CODE_01: serial_cs_n_in = pb_in[4];
            pbfs_pkg::CODE_10: serial_cs_n_in = pa_in[1];
            default: serial_cs_n_in = 1'b1;
        endcase
    end

    // Serial clock input; a master sees its own clock back
    always_comb begin
        if (spi_master_on)
            serial_clock_in = spi_sck_out;
        else begin
            unique case (sck_src)
                pbfs_pkg::CODE_00: serial_clock_in = pa_in[0];
                pbfs_pkg::CODE_10: serial_clock_in = pa_in[7];
                default: serial_clock_in = pb_in[2];
            endcase
        end
    end

    // Serial data input; reserved code gives an idle high
    always_comb begin
        unique case (sdi_src)
            pbfs_pkg::CODE_01: serial_data_in = pa_in[6];
            pbfs_pkg::CODE_10: serial_data_in = 1'b1;
            default: serial_data_in = pa_in[2];
        endcase
    end
endmodule : pbfs_top

// ===== pbfs_pkg.sv
// Constants for the port B pin function select block
package pbfs_pkg;
    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] OFS_PB_LOW_SEL = 8'h00;
    localparam logic [7:0] OFS_PB_HIGH_SEL = 8'h04;
    localparam logic [7:0] OFS_INPUT_SRC = 8'h08;
    localparam logic [7:0] OFS_PA_DATA = 8'h0c;
    localparam logic [7:0] OFS_PA_DIR = 8'h10;
    localparam logic [7:0] OFS_PB_DATA = 8'h14;
    localparam logic [7:0] OFS_PB_DIR = 8'h18;
    localparam logic [7:0] OFS_PA_WAKE_EN = 8'h1c;
    localparam logic [7:0] OFS_BIT_OP = 8'h20;
    localparam logic [7:0] OFS_WAKE_STAT = 8'h24;

    // Widths
    localparam int PA_W = 8;
    localparam int PB_W = 5;

    // Reset values
    localparam logic [7:0] RST_SEL = 8'h00;
    localparam logic [7:0] RST_PA = 8'hff;
    localparam logic [4:0] RST_PB = 5'h1f;
    localparam logic [7:0] RST_WAKE_EN = 8'h00;

    // Field positions (low bit of each two-bit field)
    localparam int LINE3_FUNC_LSB = 6;
    localparam int LINE2_FUNC_LSB = 4;
    localparam int LINE1_FUNC_LSB = 2;
    localparam int LINE0_FUNC_LSB = 0;
    localparam int LINE4_FUNC_LSB = 0;
    localparam int CAP_SRC_LSB = 6;
    localparam int CS_SRC_LSB = 4;
    localparam int SCK_SRC_LSB = 2;
    localparam int SDI_SRC_LSB = 0;
    localparam logic [7:0] PB_HIGH_MASK = 8'h03;

    // Selection codes
    localparam logic [1:0] CODE_00 = 2'h0;
    localparam logic [1:0] CODE_01 = 2'h1;
    localparam logic [1:0] CODE_10 = 2'h2;
    localparam logic [1:0] CODE_11 = 2'h3;

    // Bit operation command layout
    localparam int BOP_PORT_B = 7;
    localparam int BOP_DIR = 6;
    localparam int BOP_VAL = 5;
    localparam int BOP_IDX_LSB = 0;
    localparam int BOP_IDX_W = 3;

    // Wake status
    localparam int WAKE_FLAG_BIT = 0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : pbfs_pkg

// ===== pbfs_properties.sv
// Concurrent checks on the pin select block ports
`timescale 1ns/1ps
module pbfs_properties (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic [7:0] pa_in,
    input wire logic [7:0] pa_out,
    input wire logic [7:0] pa_oe_n,
    input wire logic [4:0] pb_in,
    input wire logic [4:0] pb_out,
    input wire logic [4:0] pb_oe_n,
    // Serial, timer and wake
    input wire logic serial_iface_enable,
    input wire logic spi_master_mode,
    input wire logic spi_sck_out,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    input wire logic serial_cs_n_in,
    input wire logic periodic_timer_capture_in,
    input wire logic sleep_idle,
    input wire logic wake_up
);
    // One clock domain, so one default clock and reset
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Handshake steps of a bus access
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_both_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    a_reset_pins_high: assert property ($rose(aresetn) |->
        pa_out == 8'hff && pa_oe_n == 8'hff && pb_out == 5'h1f
        && pb_oe_n == 5'h1f) else $error("pins not inputs after reset");
    a_write_answer: assert property (s_both_take |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_high_sel_zero: assert property (s_ar_take
        and s_axi_araddr == pbfs_pkg::OFS_PB_HIGH_SEL |=>
        s_axi_rdata[31:2] == 30'h0) else $error("high select upper bits set");
    a_master_clock: assert property (serial_iface_enable &&
        spi_master_mode |-> serial_clock_in == spi_sck_out)
        else $error("master clock not looped back");
    a_capture_source: assert property (periodic_timer_capture_in |->
        pa_in[7]) else $error("capture input without source pin");
    a_select_source: assert property (!serial_cs_n_in |->
        !pb_in[4] || !pa_in[1]) else $error("chip select from no pin");
    a_data_source: assert property (!serial_data_in |->
        !pa_in[2] || !pa_in[6]) else $error("serial data from no pin");
    a_wake_cause: assert property ($rose(wake_up) |->
        $past(sleep_idle)) else $error("wake while not sleeping");
endmodule : pbfs_properties

bind pbfs_top pbfs_properties u_props (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pa_in,
    .pa_out, .pa_oe_n, .pb_in, .pb_out, .pb_oe_n, .serial_iface_enable,
    .spi_master_mode, .spi_sck_out, .serial_clock_in, .serial_data_in,
    .serial_cs_n_in, .periodic_timer_capture_in, .sleep_idle, .wake_up);

// ===== pbfs_pin_model.sv
// Package pin levels seen by the block
`timescale 1ns/1ps
module pbfs_pin_model (
    // Design drive
    input wire logic [7:0] pa_out,
    input wire logic [7:0] pa_oe_n,
    input wire logic [4:0] pb_out,
    input wire logic [4:0] pb_oe_n,
    // Outside circuit drive
    input wire logic [7:0] pa_ext,
    input wire logic [4:0] pb_ext,
    // Levels back to the design
    output logic [7:0] pa_in,
    output logic [4:0] pb_in
);
    // Design wins where its enable is low, outside circuit elsewhere
    assign pa_in = (pa_oe_n & pa_ext) | (~pa_oe_n & pa_out);
    assign pb_in = (pb_oe_n & pb_ext) | (~pb_oe_n & pb_out);
endmodule : pbfs_pin_model

// ===== port_b_pin_function_select_test.sv
// Self-checking bench for the pin select block
`timescale 1ns/1ps
module port_b_pin_function_select_test;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, serial_clock_in, serial_data_in, serial_cs_n_in;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] pa_in, pa_out, pa_oe_n, pa_ext = 8'hff;
    logic [4:0] pb_in, pb_out, pb_oe_n, pb_ext = 5'h1f;
    logic serial_iface_enable = 1'h0, spi_master_mode = 1'h0;
    logic spi_sck_out = 1'h0, spi_sdo_out = 1'h0, sleep_idle = 1'h0;
    logic periodic_timer_capture_in, wake_up;
    logic [33:0] rq[$];
    logic [1:0] wq[$];
    int mismatches = 0, checked = 0;

    pbfs_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pa_in, .pa_out,
        .pa_oe_n, .pb_in, .pb_out, .pb_oe_n, .serial_iface_enable,
        .spi_master_mode, .spi_sck_out, .spi_sdo_out, .serial_clock_in,
        .serial_data_in, .serial_cs_n_in, .periodic_timer_capture_in,
        .sleep_idle, .wake_up);
    pbfs_pin_model u_pins (.pa_out, .pa_oe_n, .pb_out, .pb_oe_n, .pa_ext,
        .pb_ext, .pa_in, .pb_in);

    // 250 MHz clock
    always #2 aclk = ~aclk;

    task check(input string what, input logic [33:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task test_done;
        $display("Checked %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    // Write; the response is judged by the monitor
    task wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] r = pbfs_pkg::RESP_OKAY);
        @(posedge aclk);
        wq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) break;
        end
        s_axi_bready <= 1'h0;
    endtask : wr

    // Read; expected word noted for the monitor
    task rd(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] r = pbfs_pkg::RESP_OKAY);
        @(posedge aclk);
        rq.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) break;
        end
        s_axi_rready <= 1'h0;
    endtask : rd

    // Monitor takes the oldest note whenever a response is taken
    always @(posedge aclk) begin
        if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1) begin
            check("bresp", s_axi_bresp, wq.pop_front());
        end
        if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) begin
            check("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
        end
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #20000;
        mismatches++;
        test_done;
    end

    initial begin
        int c, j;
        logic [7:0] v;
        void'($urandom(82));
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        check("reset pins", {pa_out, pa_oe_n, pb_out, pb_oe_n},
            26'h3ffffff);
        rd(pbfs_pkg::OFS_PA_DIR, 32'hff);
        rd(pbfs_pkg::OFS_PB_DIR, 32'h1f);
        rd(pbfs_pkg::OFS_PB_LOW_SEL, 32'h0);
        rd(pbfs_pkg::OFS_INPUT_SRC, 32'h0);
        wr(pbfs_pkg::OFS_PB_HIGH_SEL, 32'hffffffff);
        rd(pbfs_pkg::OFS_PB_HIGH_SEL, 32'h3);
        wr(8'h30, 32'h5, pbfs_pkg::RESP_DECERR);
        rd(8'h30, 32'h0, pbfs_pkg::RESP_DECERR);
        rd(pbfs_pkg::OFS_BIT_OP, 32'h0);
        v = 8'($urandom());
        wr(pbfs_pkg::OFS_INPUT_SRC, {24'h0, v});
        rd(pbfs_pkg::OFS_INPUT_SRC, {24'h0, v});
        // Upper nibble inputs from outside, lower nibble newly outputs
        pa_ext <= 8'h3c;
        wr(pbfs_pkg::OFS_PA_DIR, 32'hf0);
        check("pa dir", {pa_oe_n, pa_out}, 16'hf0ff);
        rd(pbfs_pkg::OFS_PA_DATA, 32'h3f);
        wr(pbfs_pkg::OFS_BIT_OP, 32'h00);
        check("pa rmw", pa_out, 8'h3e);
        // Port A direction bit op: set line 0 back to input
        wr(pbfs_pkg::OFS_BIT_OP, 32'h60);
        check("pa dir rmw", pa_oe_n, 8'hf1);
        wr(pbfs_pkg::OFS_BIT_OP, 32'hc1);
        wr(pbfs_pkg::OFS_BIT_OP, 32'hc4);
        wr(pbfs_pkg::OFS_PB_DATA, 32'h0);
        check("pb dir", pb_oe_n, 5'h0d);
        // Every code of the line 1, 2 and 4 select fields
        for (c = 0; c < 4; c++) begin
            serial_iface_enable <= 1'($urandom());
            spi_master_mode <= 1'($urandom());
            spi_sck_out <= 1'h1;
            spi_sdo_out <= 1'h1;
            wr(pbfs_pkg::OFS_PB_LOW_SEL,
                {2'h0, c[1:0], c[1:0], 2'h0});
            wr(pbfs_pkg::OFS_PB_HIGH_SEL, c);
            check("pb1 out", pb_out[1], c == 2);
            check("pb2 out", pb_out[2], c == 2);
            check("pb2 oe", pb_oe_n[2], c != 2 ||
                !(serial_iface_enable && spi_master_mode));
            check("pb4 oe", pb_oe_n[4], c == 1);
        end
        wr(pbfs_pkg::OFS_PB_LOW_SEL, 32'h0);
        wr(pbfs_pkg::OFS_PB_HIGH_SEL, 32'h0);
        wr(pbfs_pkg::OFS_PB_DIR, 32'h1f);
        wr(pbfs_pkg::OFS_PA_DIR, 32'hff);
        serial_iface_enable <= 1'h0;
        // Every code of the input source fields, random pin levels
        for (c = 0; c < 4; c++) begin
            wr(pbfs_pkg::OFS_INPUT_SRC, c * 8'h55);
            for (j = 0; j < 4; j++) begin
                pa_ext <= 8'($urandom());
                pb_ext <= 5'($urandom());
                @(posedge aclk);
                @(posedge aclk);
                check("capture", periodic_timer_capture_in,
                    c == 1 ? pa_in[7] : 1'h0);
                check("cs_n", serial_cs_n_in,
                    c == 1 ? pb_in[4] : (c == 2 ? pa_in[1] : 1'h1));
                check("sck", serial_clock_in,
                    c == 0 ? pa_in[0] : (c == 2 ? pa_in[7] : pb_in[2]));
                check("sdi", serial_data_in,
                    c == 1 ? pa_in[6] : (c == 2 ? 1'h1 : pa_in[2]));
            end
        end
        // Source field is 11 here, so the routed pin is line 2
        serial_iface_enable <= 1'h1;
        spi_master_mode <= 1'h1;
        spi_sck_out <= ~pb_in[2];
        @(posedge aclk);
        @(posedge aclk);
        check("sck master", serial_clock_in, spi_sck_out);
        // Wake only on an enabled pin falling while asleep
        pa_ext <= 8'hff;
        wr(pbfs_pkg::OFS_PA_WAKE_EN, 32'h04);
        sleep_idle <= 1'h1;
        pa_ext <= 8'hdf;
        repeat (3) @(posedge aclk);
        check("wake other pin", wake_up, 1'h0);
        sleep_idle <= 1'h0;
        pa_ext <= 8'hdb;
        repeat (3) @(posedge aclk);
        check("wake awake", wake_up, 1'h0);
        sleep_idle <= 1'h1;
        pa_ext <= 8'hdf;
        repeat (3) @(posedge aclk);
        pa_ext <= 8'hdb;
        repeat (3) @(posedge aclk);
        check("wake", wake_up, 1'h1);
        wr(pbfs_pkg::OFS_WAKE_STAT, 32'h1);
        check("wake clear", wake_up, 1'h0);
        repeat (2) @(posedge aclk);
        test_done;
    end
endmodule : port_b_pin_function_select_test
